//--- verilog/hrrq_pkg.sv
// Constants and types shared by the request/reply queue block.
`default_nettype none
package hrrq_pkg;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_INBOX = 8'h00;
  localparam logic [7:0] OFS_RING_BASE = 8'h04;
  localparam logic [7:0] OFS_RING_LEN = 8'h08;
  localparam logic [7:0] OFS_HOST_MAX = 8'h0c;
  localparam logic [7:0] OFS_DEV_MAX = 8'h10;
  localparam logic [7:0] OFS_CTRL = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_FLAG = 8'h1c;
  // ----------------------------------------
  // Field positions and limits
  // ----------------------------------------
  localparam int INBOX_OP_W = 3;
  localparam logic [2:0] OP_TRANSACTION = 3'h0;
  localparam logic [2:0] OP_OTHER = 3'h1;
  localparam int CTRL_INIT_BIT = 0;
  localparam int FLAG_VALID_BIT = 0;
  localparam int ST_READY_BIT = 0;
  localparam int ST_CFG_ERR_BIT = 1;
  localparam int ST_PHASE_BIT = 2;
  localparam int ST_BUSY_BIT = 3;
  localparam int ST_CREDIT_LSB = 4;
  localparam int ST_WPTR_LSB = 16;
  localparam int LEN_W = 10;
  localparam int HOST_W = 10;
  localparam int DEV_W = 5;
  localparam logic [HOST_W-1:0] HOST_MAX_LIMIT = 10'h200;
  localparam logic [DEV_W-1:0] DEV_MAX_LIMIT = 5'h1a;
  localparam logic [LEN_W-1:0] RING_LEN_LIMIT = 10'h220;
  localparam int ELEM_BYTES = 4;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] RST_RING_BASE = 32'h0000_0000;
  localparam logic [LEN_W-1:0] RST_RING_LEN = 10'h220;
  localparam logic [HOST_W-1:0] RST_HOST_MAX = 10'h200;
  localparam logic [DEV_W-1:0] RST_DEV_MAX = 5'h1a;
  // ----------------------------------------
  // Element tags (bits 3 to 1 of an element)
  // ----------------------------------------
  localparam logic [2:0] TAG_REQUEST = 3'h0;
  localparam logic [2:0] TAG_REPLY = 3'h1;
  localparam logic [2:0] TAG_SLAVE_OK = 3'h4;
  localparam logic [2:0] TAG_SLAVE_FAIL = 3'h5;

  typedef enum logic [1:0] {
    KIND_REQUEST,
    KIND_REPLY,
    KIND_SLAVE_OK,
    KIND_SLAVE_FAIL
  } hrrq_kind_type;

  // A posting request from the adapter's own logic.
  typedef struct packed {
    hrrq_kind_type kind;
    logic result_nz;
    logic [27:0] payload;
  } hrrq_post_type;

  // A single four-byte store into host memory.
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } hrrq_store_type;

  // A block fetch ordered by an inbox write.
  typedef struct packed {
    logic other;
    logic [31:0] addr;
  } hrrq_fetch_type;
endpackage
`default_nettype wire

//--- verilog/hrrq_queue.sv
// Inbox register and completion ring producer of the host request/reply queue.
//
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Inbox: pointer bits 31-3, opcode bits 2-0
// - Opcode zero issues a transaction block
// - Opcode one issues slave operation or command
// - Valid opcodes fetch the pointed block by DMA
// - Post four-byte elements into host ring
// - Tag 000x carries device transaction request
// - Tag 001x carries reply handle
// - Tag 100x reports slave operation success
// - Tag 101x reports slave operation failure
// - Bit 0 carries the phase flag
// - Keep one free plus host reply space
// - Limits: host 1-512, device 1-26, length
// - Init: pointer start, phase zero, full credit
// - Request needs credit, then credit decrements
// - Prepare block or result before posting
// - One atomic store with tag and phase
// - Set ring-valid flag after store
// - Advance pointer, toggle phase on wrap
module hrrq_queue (
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Block fetch toward the DMA engine.
  output logic fetch_valid_o,
  output hrrq_pkg::hrrq_fetch_type fetch_o,
  input wire logic fetch_ready_i,
  // Posting requests from adapter logic.
  input wire logic post_valid_i,
  input wire hrrq_pkg::hrrq_post_type post_i,
  output logic post_ready_o,
  input wire logic credit_return_i,
  // Local preparation of blocks and result words.
  output logic prep_valid_o,
  output hrrq_pkg::hrrq_kind_type prep_kind_o,
  input wire logic prep_done_i,
  // Element store toward the DMA engine.
  output logic store_valid_o,
  output hrrq_pkg::hrrq_store_type store_o,
  input wire logic store_ready_i,
  // Ring-valid interrupt flag level.
  output logic ring_valid_o
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  // The posting sequence has three steps. Idle waits for a post from the
  // adapter logic. Prep waits while the local block or result word is built.
  // Store holds one element toward the DMA engine until it is taken.
  // Only one post is in flight at a time, so the ring never sees two stores
  // racing for the same write index.
  typedef enum logic [1:0] {ST_IDLE, ST_PREP, ST_STORE} hrrq_state_type;

  hrrq_state_type state_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [31:0] ring_base_reg;
  logic [hrrq_pkg::LEN_W-1:0] ring_len_reg;
  logic [hrrq_pkg::HOST_W-1:0] host_max_reg;
  logic [hrrq_pkg::DEV_W-1:0] dev_max_reg;
  logic ready_reg;
  logic cfg_err_reg;
  logic phase_reg;
  logic [hrrq_pkg::LEN_W-1:0] wptr_reg;
  logic [hrrq_pkg::LEN_W-1:0] wptr_next;
  logic [hrrq_pkg::DEV_W-1:0] credit_reg;
  logic [hrrq_pkg::DEV_W-1:0] credit_next;
  logic flag_reg;
  logic fetch_valid_reg;
  hrrq_pkg::hrrq_fetch_type fetch_reg;
  hrrq_pkg::hrrq_post_type cur_reg;
  hrrq_pkg::hrrq_store_type store_reg;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Ring tag for an element kind.
  function automatic logic [2:0] tag_of(input hrrq_pkg::hrrq_kind_type k);
    logic [2:0] t;
    unique case (k)
      hrrq_pkg::KIND_REQUEST: t = hrrq_pkg::TAG_REQUEST;
      hrrq_pkg::KIND_REPLY: t = hrrq_pkg::TAG_REPLY;
      hrrq_pkg::KIND_SLAVE_OK: t = hrrq_pkg::TAG_SLAVE_OK;
      hrrq_pkg::KIND_SLAVE_FAIL: t = hrrq_pkg::TAG_SLAVE_FAIL;
    endcase
    return t;
  endfunction

  // Whether a kind must be prepared locally before its element is stored.
  function automatic logic needs_prep(input hrrq_pkg::hrrq_post_type p);
    return (p.kind == hrrq_pkg::KIND_REQUEST) ||
           (p.kind == hrrq_pkg::KIND_REPLY && p.result_nz);
  endfunction

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Every access is answered one cycle after it is taken.
  // The request is masked while ack stands, so a master that holds its
  // strobe through the acknowledge edge is not taken a second time.
  // Partial writes are acknowledged but change nothing, because every
  // register here is a whole word to software.
  // Register hits and the one-cycle access strobe.
  wire req = cyc_i && stb_i && !ack_reg;
  wire hit_inbox = adr_i == hrrq_pkg::OFS_INBOX;
  wire hit_base = adr_i == hrrq_pkg::OFS_RING_BASE;
  wire hit_len = adr_i == hrrq_pkg::OFS_RING_LEN;
  wire hit_host = adr_i == hrrq_pkg::OFS_HOST_MAX;
  wire hit_dev = adr_i == hrrq_pkg::OFS_DEV_MAX;
  wire hit_ctrl = adr_i == hrrq_pkg::OFS_CTRL;
  wire hit_stat = adr_i == hrrq_pkg::OFS_STATUS;
  wire hit_flag = adr_i == hrrq_pkg::OFS_FLAG;
  wire full_word = sel_i == 4'hf;
  // An inbox write waits while an earlier fetch is still pending.
  wire inbox_stall = hit_inbox && we_i && fetch_valid_reg;
  wire take = req && !inbox_stall;
  wire wr = take && we_i && full_word;
  wire [2:0] inbox_op = dat_i[hrrq_pkg::INBOX_OP_W-1:0];
  wire inbox_fetch = wr && hit_inbox &&
    (inbox_op == hrrq_pkg::OP_TRANSACTION || inbox_op == hrrq_pkg::OP_OTHER);
  wire init_cmd = wr && hit_ctrl && dat_i[hrrq_pkg::CTRL_INIT_BIT];
  wire flag_clr = wr && hit_flag && dat_i[hrrq_pkg::FLAG_VALID_BIT];

  wire [hrrq_pkg::LEN_W:0] len_need = {1'b0, host_max_reg} +
    {{(hrrq_pkg::LEN_W-hrrq_pkg::DEV_W+1){1'b0}}, dev_max_reg} + 11'h001;
  wire cfg_ok = host_max_reg != '0 && host_max_reg <= hrrq_pkg::HOST_MAX_LIMIT &&
    dev_max_reg != '0 && dev_max_reg <= hrrq_pkg::DEV_MAX_LIMIT &&
    {1'b0, ring_len_reg} >= len_need && ring_len_reg <= hrrq_pkg::RING_LEN_LIMIT;

  // Read data mux; the inbox is write-only and reads as zero.
  wire [31:0] status_word = ({31'h0, ready_reg} << hrrq_pkg::ST_READY_BIT) |
    ({31'h0, cfg_err_reg} << hrrq_pkg::ST_CFG_ERR_BIT) |
    ({31'h0, phase_reg} << hrrq_pkg::ST_PHASE_BIT) |
    ({31'h0, state_reg != ST_IDLE} << hrrq_pkg::ST_BUSY_BIT) |
    ({27'h0, credit_reg} << hrrq_pkg::ST_CREDIT_LSB) |
    ({22'h0, wptr_reg} << hrrq_pkg::ST_WPTR_LSB);
  wire [31:0] rd_mux = hit_base ? ring_base_reg :
    hit_len ? {22'h0, ring_len_reg} :
    hit_host ? {22'h0, host_max_reg} :
    hit_dev ? {27'h0, dev_max_reg} :
    hit_stat ? status_word :
    hit_flag ? {31'h0, flag_reg} : 32'h0000_0000;

  // ----------------------------------------
  // Ring producer decode
  // ----------------------------------------
  // A post is offered only while the ring has been set up and nothing else
  // is in flight. Requests also need a device credit, which keeps room in
  // the ring for every reply the host may still be owed.
  // Replies and slave reports never consume credit.
  // requests need credit
  wire can_post = state_reg == ST_IDLE && ready_reg &&
    (post_i.kind != hrrq_pkg::KIND_REQUEST || credit_reg != '0);
  wire post_take = post_valid_i && can_post;
  wire store_done = state_reg == ST_STORE && store_ready_i;
  wire prep_end = state_reg == ST_PREP && prep_done_i;
  wire wrap = wptr_reg == ring_len_reg - 10'h001;
  wire is_req = cur_reg.kind == hrrq_pkg::KIND_REQUEST;
  wire cr_inc = credit_return_i && credit_reg < dev_max_reg;
  wire cr_dec = store_done && is_req;

  // Next write pointer and credit.
  always_comb begin
    wptr_next = wptr_reg;
    credit_next = credit_reg;
    if (store_done) begin
      wptr_next = wrap ? '0 : wptr_reg + 10'h001;
    end
    if (cr_inc && !cr_dec) begin
      credit_next = credit_reg + 5'h01;
    end else if (cr_dec && !cr_inc) begin
      credit_next = credit_reg - 5'h01;
    end
  end

  // Element address and contents for the current post.
  // four-byte ring element
  wire [31:0] elem_addr = ring_base_reg +
    {20'h0, wptr_reg, 2'h0} * hrrq_pkg::ELEM_BYTES / 4;
  wire [31:0] elem_data = {cur_reg.payload, tag_of(cur_reg.kind), phase_reg};

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  // Read data is captured only on a taken read, so it stays put after the
  // acknowledge and a later write does not disturb what software saw.
  // Registered acknowledge and read data; unmapped reads return zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_reg <= take;
      if (take && !we_i) begin
        dat_reg <= rd_mux;
      end
    end
  end

  // Configuration registers; full-word writes only.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ring_base_reg <= hrrq_pkg::RST_RING_BASE;
      ring_len_reg <= hrrq_pkg::RST_RING_LEN;
      host_max_reg <= hrrq_pkg::RST_HOST_MAX;
      dev_max_reg <= hrrq_pkg::RST_DEV_MAX;
    end else if (ce_i && wr) begin
      if (hit_base) ring_base_reg <= {dat_i[31:2], 2'h0};
      if (hit_len) ring_len_reg <= dat_i[hrrq_pkg::LEN_W-1:0];
      if (hit_host) host_max_reg <= dat_i[hrrq_pkg::HOST_W-1:0];
      if (hit_dev) dev_max_reg <= dat_i[hrrq_pkg::DEV_W-1:0];
    end
  end

  // ----------------------------------------
  // Inbox fetch
  // ----------------------------------------
  // Only one fetch order is kept. A second inbox write is held off on the
  // bus until the DMA engine has taken the first, so no order is lost.
  // Reserved opcodes are acknowledged and dropped without any side effect.
  // split pointer and opcode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fetch_valid_reg <= 1'b0;
      fetch_reg <= '0;
    end else if (ce_i) begin
      if (inbox_fetch) begin
        fetch_valid_reg <= 1'b1;
        fetch_reg.addr <= {dat_i[31:3], 3'h0};
        fetch_reg.other <= inbox_op == hrrq_pkg::OP_OTHER;
      end else if (fetch_ready_i) begin
        fetch_valid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Ring state
  // ----------------------------------------
  // The initialise command wins over any store finishing in the same cycle.
  // Software must not start it while a post is in flight, since the element
  // being stored would then land at a stale index.
  // A bad configuration leaves the ring not ready and sets the error bit.
  // initialise pointer, phase, credit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_reg <= 1'b0;
      cfg_err_reg <= 1'b0;
      phase_reg <= 1'b0;
      wptr_reg <= '0;
      credit_reg <= '0;
    end else if (ce_i) begin
      if (init_cmd) begin
        ready_reg <= cfg_ok;
        cfg_err_reg <= !cfg_ok;
        phase_reg <= 1'b0;
        wptr_reg <= '0;
        credit_reg <= dev_max_reg;
      end else begin
        wptr_reg <= wptr_next;
        credit_reg <= credit_next;
        if (store_done && wrap) begin
          phase_reg <= !phase_reg;
        end
      end
    end
  end

  // ring-valid flag, set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_reg <= 1'b0;
    end else if (ce_i) begin
      flag_reg <= store_done || (flag_reg && !flag_clr);
    end
  end

  // ----------------------------------------
  // Posting sequence
  // ----------------------------------------
  // Requests and replies with a non-zero result wait for the local builder
  // before their element is stored. The host may follow an element at once,
  // so whatever it points at must already be in place.
  // prepare locally first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      cur_reg <= '0;
      store_reg <= '0;
    end else if (ce_i) begin
      unique case (state_reg)
        ST_IDLE: begin
          if (post_take) begin
            cur_reg <= post_i;
            state_reg <= needs_prep(post_i) ? ST_PREP : ST_STORE;
          end
        end
        ST_PREP: begin
          if (prep_end) begin
            state_reg <= ST_STORE;
          end
        end
        ST_STORE: begin
          if (store_done) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Store word follows the current element and pointer.
  always_comb begin
    store_o.addr = elem_addr;
    store_o.data = elem_data;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign dat_o = dat_reg;
  assign ack_o = ack_reg;
  assign fetch_valid_o = fetch_valid_reg;
  assign fetch_o = fetch_reg;
  assign post_ready_o = can_post;
  assign prep_valid_o = state_reg == ST_PREP;
  assign prep_kind_o = cur_reg.kind;
  assign store_valid_o = state_reg == ST_STORE;
  assign ring_valid_o = flag_reg;
endmodule // hrrq_queue
`default_nettype wire

//--- verification/hrrq_monitor.sv
// Port checker of the request/reply queue.
`timescale 1ns/1ps
`default_nettype none
module hrrq_monitor (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  // Fetch, post and store.
  input wire logic fetch_valid_o,
  input wire hrrq_pkg::hrrq_fetch_type fetch_o,
  input wire logic fetch_ready_i,
  input wire logic post_valid_i,
  input wire hrrq_pkg::hrrq_post_type post_i,
  input wire logic post_ready_o,
  input wire logic prep_valid_o,
  input wire hrrq_pkg::hrrq_kind_type prep_kind_o,
  input wire logic store_valid_o,
  input wire hrrq_pkg::hrrq_store_type store_o,
  input wire logic store_ready_i,
  input wire logic ring_valid_o
);
  // --------------------------------
  // Handshake events and checks
  // --------------------------------
  // Inbox write taken, post taken and store taken.
  wire inbox_wr = cyc_i && stb_i && we_i && !ack_o && !fetch_valid_o && sel_i == 4'hf &&
    adr_i == hrrq_pkg::OFS_INBOX;
  wire post_go = post_valid_i && post_ready_o;
  wire store_go = store_valid_o && store_ready_i;
  hrrq_pkg::hrrq_fetch_type exp_f;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Fetch order expected from the last inbox write.
  always_ff @(posedge clk_i) begin
    if (inbox_wr) exp_f <= '{dat_i[0], {dat_i[31:3], 3'h0}};
  end
  a_ack_one_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack stood two cycles");
  a_fetch_on_op: assert property (inbox_wr && dat_i[2:1] == 2'h0 |->
    ##[1:2] (fetch_valid_o && fetch_o == exp_f)) else $error("fetch wrong or missing");
  a_reserved_none: assert property (inbox_wr && dat_i[2:1] != 2'h0 |=> !fetch_valid_o [*2])
    else $error("reserved opcode fetched");
  a_fetch_hold: assert property (fetch_valid_o && !fetch_ready_i |=>
    fetch_valid_o && $stable(fetch_o)) else $error("fetch dropped");
  a_slave_ok_elem: assert property (post_go && post_i.kind == hrrq_pkg::KIND_SLAVE_OK |=>
    store_valid_o && store_o.data[31:1] == {$past(post_i.payload), hrrq_pkg::TAG_SLAVE_OK})
    else $error("slave ok element wrong");
  a_slave_fail_tag: assert property (post_go && post_i.kind == hrrq_pkg::KIND_SLAVE_FAIL ##1 1
    |-> store_valid_o && store_o.data[3:1] == hrrq_pkg::TAG_SLAVE_FAIL) else $error("fail tag");
  a_request_prep: assert property (post_go && post_i.kind == hrrq_pkg::KIND_REQUEST |=>
    prep_valid_o && !store_valid_o) else $error("request stored unprepared");
  a_prep_kind_match: assert property (post_go && (post_i.kind == hrrq_pkg::KIND_REQUEST ||
    (post_i.kind == hrrq_pkg::KIND_REPLY && post_i.result_nz)) |=>
    prep_valid_o && prep_kind_o == $past(post_i.kind)) else $error("prepared kind wrong");
  a_store_hold: assert property (store_valid_o && !store_ready_i |=>
    store_valid_o && $stable(store_o)) else $error("store changed while waiting");
  a_flag_after_store: assert property (store_go |=> ring_valid_o)
    else $error("ring flag not set");
  a_busy_no_post: assert property (store_valid_o || prep_valid_o |-> !post_ready_o)
    else $error("post ready while busy");
  cover property (fetch_valid_o && fetch_ready_i);
  cover property (store_go && store_o.data[0]);
  cover property (prep_valid_o ##1 store_valid_o);
endmodule // hrrq_monitor
bind hrrq_queue hrrq_monitor u_mon (.*);
`default_nettype wire

//--- verification/hrrq_host_model.sv
// Stand-in for the DMA engine and the local block builder.
`timescale 1ns/1ps
`default_nettype none
module hrrq_host_model (
  // Clock, reset and pace.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  // Handshakes.
  input wire logic prep_valid_i,
  output logic fetch_ready_o,
  output logic store_ready_o,
  output logic prep_done_o
);
  int seed = 32'hfd12;
  logic [2:0] r;
  // Ready lines stall at random when slow; one done pulse answers each prep.
  // block built locally
  always @(posedge clk_i) begin
    r = 3'($random(seed));
    fetch_ready_o <= !rst_i && (!slow_i || r[0]);
    store_ready_o <= !rst_i && (!slow_i || r[1]);
    prep_done_o <= !rst_i && prep_valid_i && !prep_done_o && (!slow_i || r[2]);
  end
endmodule // hrrq_host_model
`default_nettype wire

//--- verification/hrrq_queue_tb.sv
// Self-checking bench of the request/reply queue.
`timescale 1ns/1ps
`default_nettype none
module hrrq_queue_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic post_valid_i = 1'b0, credit_return_i = 1'b0, slow = 1'b0;
  logic [3:0] sel_i = 4'hf;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o, v;
  logic ack_o, fetch_valid_o, fetch_ready_i, post_ready_o, prep_valid_o, prep_done_i;
  logic store_valid_o, store_ready_i, ring_valid_o;
  logic [63:0] w;
  hrrq_pkg::hrrq_fetch_type fetch_o;
  hrrq_pkg::hrrq_post_type post_i = '0;
  hrrq_pkg::hrrq_kind_type prep_kind_o;
  hrrq_pkg::hrrq_store_type store_o;
  int fails = 0, n_tests = 0, seed = 32'hfd12, idx = 0, ph = 0;
  logic [63:0] rq[$], fq[$], sq[$];
  hrrq_queue dut (.*);
  hrrq_host_model u_host (.clk_i, .rst_i, .slow_i(slow), .prep_valid_i(prep_valid_o),
    .fetch_ready_o(fetch_ready_i), .store_ready_o(store_ready_i), .prep_done_o(prep_done_i));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Compares one value and counts it.
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // One classic bus cycle, held until acknowledged.
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= wr;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 200);
    if (n == 200) fails++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  // Read whose masked answer is noted for the watcher.
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rq.push_back({m, e});
    wb(1'b0, a, 32'h0);
  endtask
  // Offers one post and notes the element it must store.
  task automatic post(input hrrq_pkg::hrrq_kind_type k);
    logic [27:0] p;
    int n;
    p = 28'($random(seed));
    n = 0;
    sq.push_back({32'h100 + 32'(4 * idx), p, k[1], 1'b0, k[0], 1'(ph)});
    if (++idx == 4) begin
      idx = 0;
      ph ^= 1;
    end
    @(posedge clk_i);
    post_valid_i <= 1'b1;
    post_i <= '{k, 1'($random(seed)), p};
    do @(posedge clk_i); while (post_ready_o !== 1'b1 && ++n < 200);
    if (n == 200) fails++;
    post_valid_i <= 1'b0;
  endtask
  task automatic report_and_stop;
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------
  // Clock, watchers and sequence
  // ----------------------------------------
  initial forever #12.5 clk_i = ~clk_i;
  // Cuts a hang short.
  initial begin
    #2000000;
    fails++;
    report_and_stop;
  end
  // Each read answer, fetch and store is compared with the oldest note.
  always @(negedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      w = rq.pop_front();
      chk(64'(dat_o & w[63:32]), 64'(w[31:0]));
    end
    if ((fetch_valid_o & fetch_ready_i) === 1'b1) chk(64'(fetch_o), fq.pop_front());
    if ((store_valid_o & store_ready_i) === 1'b1) chk(store_o, sq.pop_front());
  end
  // Main sequence: reset values, bad and good setup, inbox codes, posts, flag.
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(hrrq_pkg::OFS_RING_LEN, 32'h220, '1);
    rd(hrrq_pkg::OFS_HOST_MAX, 32'h200, '1);
    rd(8'h20, 32'h0, '1);
    wb(1'b1, hrrq_pkg::OFS_HOST_MAX, 32'h1);
    wb(1'b1, hrrq_pkg::OFS_DEV_MAX, 32'h2);
    wb(1'b1, hrrq_pkg::OFS_RING_LEN, 32'h3);
    wb(1'b1, hrrq_pkg::OFS_CTRL, 32'h1);
    rd(hrrq_pkg::OFS_STATUS, 32'h2, 32'h3);
    wb(1'b1, hrrq_pkg::OFS_RING_LEN, 32'h4);
    // host tracking starts at ring start
    wb(1'b1, hrrq_pkg::OFS_RING_BASE, 32'h100);
    wb(1'b1, hrrq_pkg::OFS_CTRL, 32'h1);
    rd(hrrq_pkg::OFS_STATUS, 32'h21, 32'h03ff_01ff);
    slow <= 1'b1;
    for (int op = 0; op < 8; op++) begin
      v = $random(seed);
      if (op < 2) fq.push_back(64'({op[0], v[31:3], 3'h0}));
      wb(1'b1, hrrq_pkg::OFS_INBOX, {v[31:3], op[2:0]});
    end
    post(hrrq_pkg::KIND_SLAVE_OK);
    post(hrrq_pkg::KIND_REPLY);
    post(hrrq_pkg::KIND_REQUEST);
    post(hrrq_pkg::KIND_SLAVE_FAIL);
    post(hrrq_pkg::KIND_REQUEST);
    @(posedge clk_i);
    post_valid_i <= 1'b1;
    post_i <= '{hrrq_pkg::KIND_REQUEST, 1'b0, 28'h0};
    repeat (40) @(negedge clk_i);
    chk(64'(post_ready_o), 64'h0);
    @(posedge clk_i);
    post_valid_i <= 1'b0;
    credit_return_i <= 1'b1;
    @(posedge clk_i);
    credit_return_i <= 1'b0;
    post(hrrq_pkg::KIND_REQUEST);
    repeat (40) @(posedge clk_i);
    rd(hrrq_pkg::OFS_STATUS, 32'h0002_0005, 32'h03ff_01ff);
    rd(hrrq_pkg::OFS_FLAG, 32'h1, 32'h1);
    wb(1'b1, hrrq_pkg::OFS_FLAG, 32'h1);
    rd(hrrq_pkg::OFS_FLAG, 32'h0, 32'h1);
    chk(64'(fq.size() + sq.size() + rq.size()), 64'h0);
    report_and_stop;
  end
endmodule // hrrq_queue_tb
`default_nettype wire
